// ### core/bfl_exec.sv
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - register bit into transfer flag, one cycle
// - transfer flag into register bit, flags kept
// - flag set touches only its flag
// - flag clear touches only its flag
// - post-increment load reads, then bumps pointer
// - pre-decrement load drops pointer, then reads
// - displaced load adds offset, pointer unchanged
// - absolute load reads address, flags untouched
// - post-increment store writes, then bumps pointer
// - pre-decrement store drops pointer, then writes
module bfl_exec (
   input  wire logic        REF_CLK,
   input  wire logic        RESET_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic             PREADY,
   output logic [31:0]      PRDATA,
   output logic             PSLVERR,
   output logic [15:0]      DMEM_ADDR,
   output logic [7:0]       DMEM_WDATA,
   output logic             DMEM_WE,
   output logic             DMEM_RE,
   input  wire logic [7:0]  DMEM_RDATA,
   output logic [7:0]       STATUS_FLAGS,
   output logic             INTERRUPTS_ON
);
   bfl_pkg::bfl_state_e                st_ff;
   bfl_pkg::bfl_state_e                nxt_st;
   logic [bfl_pkg::CMD_W-1:0]          cmd_ff;
   logic [15:0]                        arg_ff;
   logic [7:0]                         flag_ff;
   logic                               bad_ff;
   logic                               pready_ff;
   logic                               pslverr_ff;
   logic                               pend_ff;
   logic [31:0]                        prdata_ff;
   logic [15:0]                        addr_ff;
   logic [7:0]                         wdata_ff;
   logic                               we_ff;
   logic                               re_ff;
   logic [15:0]                        ptr_nxt_ff;

   bfl_rf_if rf (.clk(REF_CLK));

   bfl_regfile #(
      .DEPTH(32)
   ) u_rf (
      .rf(rf)
   );

   // command fields
   wire [4:0]  op    = cmd_ff[bfl_pkg::OPC_LSB +: 5];
   wire [4:0]  dst   = cmd_ff[bfl_pkg::DST_LSB +: 5];
   wire [4:0]  src   = cmd_ff[bfl_pkg::SRC_LSB +: 5];
   wire [2:0]  bsel  = cmd_ff[bfl_pkg::SEL_LSB +: 3];
   wire [1:0]  psel  = cmd_ff[bfl_pkg::PTR_LSB +: 2];
   wire [1:0]  mode  = cmd_ff[bfl_pkg::MODE_LSB +: 2];

   // operation decode
   wire is_b2t  = op == bfl_pkg::OP_B2T;
   wire is_t2b  = op == bfl_pkg::OP_T2B;
   wire is_fset = op == bfl_pkg::OP_FSET;
   wire is_fclr = op == bfl_pkg::OP_FCLR;
   wire is_mov  = op == bfl_pkg::OP_MOV;
   wire is_pcpy = op == bfl_pkg::OP_PCPY;
   wire is_imm  = op == bfl_pkg::OP_IMM;
   wire is_ldp  = op == bfl_pkg::OP_LD;
   wire is_dsp  = op == bfl_pkg::OP_DSP;
   wire is_abs  = op == bfl_pkg::OP_ABS;
   wire is_st   = op == bfl_pkg::OP_ST;
   wire is_ld   = is_ldp | is_dsp | is_abs;
   wire is_mem  = is_ld | is_st;
   wire use_ptr = is_ldp | is_dsp | is_st;
   wire moded   = is_ldp | is_st;

   // refused commands: unknown code, no such pointer, no such mode, displaced load through X
   wire bad_op = (op > bfl_pkg::OP_ST)
               | (use_ptr & (psel == bfl_pkg::PTR_INVAL))
               | (moded & (mode == bfl_pkg::MODE_INVAL))
               | (is_dsp & (psel == bfl_pkg::PTR_X));

   // state decode
   wire idle   = st_ff == bfl_pkg::ST_IDLE;
   wire in_ex  = st_ff == bfl_pkg::ST_EXEC;
   wire in_acc = st_ff == bfl_pkg::ST_ACCESS;
   wire in_wb  = st_ff == bfl_pkg::ST_WB;
   wire ex     = in_ex & ~bad_op;

   // pointer arithmetic on the pair read in the issue cycle
   wire [4:0]  ptr_reg  = bfl_pkg::PTR_BASE + {2'b00, psel, 1'b0};
   wire [15:0] ptr_inc  = rf.pd + 16'h0001;
   wire [15:0] ptr_dec  = rf.pd - 16'h0001;
   wire [15:0] disp     = {10'h000, arg_ff[bfl_pkg::DISP_W-1:0]};
   wire [15:0] ptr_disp = rf.pd + disp;
   wire        ptr_upd  = moded & (mode != bfl_pkg::MODE_PLAIN);
   wire [15:0] ptr_new  = (mode == bfl_pkg::MODE_INC) ? ptr_inc : ptr_dec;

   wire [15:0] eff_addr = is_abs ? arg_ff
                        : is_dsp ? ptr_disp
                        : (mode == bfl_pkg::MODE_DEC) ? ptr_dec
                        : rf.pd;

   // bit and flag masks
   wire [7:0] flg_mask = 8'h01 << bsel;
   wire       sd_bit   = rf.sd[bsel];
   wire       t_flag   = flag_ff[bfl_pkg::FLG_T];

   wire [7:0] t2b_val  = (rf.sd & ~flg_mask) | (t_flag ? flg_mask : 8'h00);

   // apb decode, every register on an aligned word
   wire apb_acc  = PSEL & PENABLE;
   wire apb_done = apb_acc & pready_ff;
   wire a_cmd    = PADDR == bfl_pkg::ADDR_CMD;
   wire a_arg    = PADDR == bfl_pkg::ADDR_ARG;
   wire a_stat   = PADDR == bfl_pkg::ADDR_STAT;
   wire a_rf     = (PADDR[7] == bfl_pkg::ADDR_RF[7]) & (PADDR[1:0] == 2'b00);
   wire a_ok     = a_cmd | a_arg | a_stat | a_rf;
   wire wr_cmd   = apb_done & PWRITE & a_cmd;
   wire wr_arg   = apb_done & PWRITE & a_arg;
   wire wr_stat  = apb_done & PWRITE & a_stat;
   wire wr_rf    = apb_done & PWRITE & a_rf;

   // register file reads need one extra cycle of wait state
   wire rf_wait  = a_rf & ~PWRITE & ~pend_ff;
   wire can_ans  = apb_acc & ~pready_ff & idle;

   wire [31:0] rd_val = a_cmd  ? {10'h000, cmd_ff}
                      : a_arg  ? {16'h0000, arg_ff}
                      : a_stat ? {22'h000000, bad_ff, ~idle, flag_ff}
                      : a_rf   ? {24'h000000, rf.sd}
                      : 32'h00000000;

   // register file read addresses
   assign rf.pa = is_pcpy ? {src[4:1], 1'b0} : ptr_reg;
   assign rf.sa = idle ? PADDR[6:2] : (is_t2b ? dst : src);

   wire wr_exec = ex & (is_t2b | is_mov | is_pcpy | is_imm);
   wire wr_ptr  = ptr_upd & ((is_ld & in_acc) | (is_st & in_wb));
   wire wr_load = is_ld & in_wb;

   wire [7:0] dst_byte = wr_load ? DMEM_RDATA
                       : is_t2b  ? t2b_val
                       : is_imm  ? arg_ff[7:0]
                       : rf.sd;

   // register file write port, apb has it only while idle
   assign rf.we    = wr_rf | wr_exec | wr_ptr | wr_load;
   assign rf.wpair = wr_ptr | (wr_exec & is_pcpy);
   assign rf.wa    = wr_rf   ? PADDR[6:2]
                   : wr_ptr  ? ptr_reg
                   : is_pcpy ? {dst[4:1], 1'b0}
                   : dst;
   assign rf.wd    = wr_rf   ? {8'h00, PWDATA[7:0]}
                   : wr_ptr  ? ptr_nxt_ff
                   : (is_pcpy & ~wr_load) ? rf.pd
                   : {8'h00, dst_byte};

   wire [7:0] nxt_flag = wr_stat ? PWDATA[7:0]
                       : ~ex     ? flag_ff
                       : is_b2t  ? ((flag_ff & ~bfl_pkg::T_MASK) | (sd_bit ? bfl_pkg::T_MASK : 8'h00))
                       : is_fset ? (flag_ff | flg_mask)
                       : is_fclr ? (flag_ff & ~flg_mask)
                       : flag_ff;

   // one cycle for register work, two more for memory work
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         bfl_pkg::ST_IDLE: begin
            if (wr_cmd) begin
               nxt_st = bfl_pkg::ST_ISSUE;
            end
         end
         bfl_pkg::ST_ISSUE: begin
            nxt_st = bfl_pkg::ST_EXEC;
         end
         bfl_pkg::ST_EXEC: begin
            nxt_st = (is_mem & ~bad_op) ? bfl_pkg::ST_ACCESS : bfl_pkg::ST_IDLE;
         end
         bfl_pkg::ST_ACCESS: begin
            nxt_st = bfl_pkg::ST_WB;
         end
         bfl_pkg::ST_WB: begin
            nxt_st = bfl_pkg::ST_IDLE;
         end
         default: begin
            nxt_st = bfl_pkg::ST_IDLE;
         end
      endcase
   end

   // sequencer state
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st_ff <= bfl_pkg::ST_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // command and argument, written only while idle
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cmd_ff <= '0;
         arg_ff <= 16'h0000;
      end else begin
         if (wr_cmd) cmd_ff <= PWDATA[bfl_pkg::CMD_W-1:0];
         if (wr_arg) arg_ff <= PWDATA[15:0];
      end
   end

   // flags; refused command sticky, set wins over the write-one clear
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         flag_ff <= bfl_pkg::FLAG_RST;
         bad_ff  <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
         bad_ff  <= (bad_ff & ~(wr_stat & PWDATA[bfl_pkg::STAT_BAD])) | (in_ex & bad_op);
      end
   end

   // data memory request, launched from exec so the pins come from flops
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         addr_ff    <= 16'h0000;
         wdata_ff   <= 8'h00;
         we_ff      <= 1'b0;
         re_ff      <= 1'b0;
         ptr_nxt_ff <= 16'h0000;
      end else if (ex & is_mem) begin
         addr_ff    <= eff_addr;
         wdata_ff   <= rf.sd;
         we_ff      <= is_st;
         re_ff      <= is_ld;
         ptr_nxt_ff <= ptr_new;
      end else begin
         we_ff      <= 1'b0;
         re_ff      <= 1'b0;
      end
   end

   // apb answer; a busy sequencer simply stretches the access phase
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         pend_ff    <= 1'b0;
         prdata_ff  <= 32'h00000000;
      end else begin
         pready_ff  <= can_ans & ~rf_wait;
         pslverr_ff <= can_ans & ~rf_wait & ~a_ok;
         pend_ff    <= can_ans & rf_wait;
         if (can_ans & ~rf_wait) prdata_ff <= rd_val;
      end
   end

   assign PREADY        = pready_ff;
   assign PSLVERR       = pslverr_ff;
   assign PRDATA        = prdata_ff;
   assign DMEM_ADDR     = addr_ff;
   assign DMEM_WDATA    = wdata_ff;
   assign DMEM_WE       = we_ff;
   assign DMEM_RE       = re_ff;
   assign STATUS_FLAGS  = flag_ff;
   assign INTERRUPTS_ON = flag_ff[bfl_pkg::FLG_I];

   // checks on the executed behaviour
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);

   AST_BIT_TO_FLAG: assert property (
      ex && is_b2t |=> idle && t_flag == $past(sd_bit)
         && flag_ff[5:0] == $past(flag_ff[5:0]))
      else $error("transfer flag not taken from register bit");

   AST_FLAG_TO_BIT: assert property (
      ex && is_t2b |-> rf.we && rf.wd[7:0] == t2b_val && rf.wa == dst
         ##1 idle && $stable(flag_ff))
      else $error("flag to bit write wrong or flags moved");

   AST_FLAG_SET: assert property (
      ex && is_fset |=> flag_ff == ($past(flag_ff) | $past(flg_mask)) && idle)
      else $error("flag set touched other flags");

   AST_FLAG_CLR: assert property (
      ex && is_fclr |=> flag_ff == ($past(flag_ff) & ~$past(flg_mask)) && idle)
      else $error("flag clear touched other flags");

   AST_LD_POSTINC: assert property (
      ex && is_ldp && mode == bfl_pkg::MODE_INC |=> DMEM_RE && DMEM_ADDR == $past(rf.pd)
         && rf.we && rf.wpair && rf.wd == DMEM_ADDR + 16'h0001 ##1 rf.we && rf.wa == dst ##1 idle)
      else $error("post-increment load order wrong");

   AST_PREDEC: assert property (
      ex && moded && mode == bfl_pkg::MODE_DEC |=> DMEM_ADDR == $past(rf.pd) - 16'h0001
         && ptr_nxt_ff == DMEM_ADDR ##1 in_wb ##1 idle)
      else $error("pre-decrement address wrong");

   AST_LD_DISP: assert property (
      ex && is_dsp |=> DMEM_RE && DMEM_ADDR == $past(rf.pd) + $past(disp) && !rf.we
         ##1 rf.wa == dst && !rf.wpair)
      else $error("displaced load address or pointer wrong");

   AST_LD_ABS: assert property (
      ex && is_abs |=> DMEM_ADDR == $past(arg_ff) && DMEM_RE
         ##1 $stable(flag_ff) && rf.we ##1 $stable(flag_ff))
      else $error("absolute load wrong or flags moved");

   AST_ST_POSTINC: assert property (
      ex && is_st && mode == bfl_pkg::MODE_INC |=> DMEM_WE && DMEM_WDATA == $past(rf.sd)
         && !rf.we ##1 rf.we && rf.wpair && rf.wd == $past(DMEM_ADDR) + 16'h0001)
      else $error("post-increment store order wrong");

   AST_ST_PREDEC: assert property (
      ex && is_st && mode == bfl_pkg::MODE_DEC |=> DMEM_WE
         && DMEM_ADDR == $past(rf.pd) - 16'h0001 ##1 rf.wd == $past(DMEM_ADDR) && $stable(flag_ff))
      else $error("pre-decrement store wrong");

   AST_PAIR_COPY: assert property (
      ex && is_pcpy |-> rf.we && rf.wpair && rf.wd == rf.pd && rf.wa[0] == 1'b0 ##1 idle)
      else $error("pair copy not written as one pair");

   AST_PLAIN_PTR: assert property (
      ex && moded && mode == bfl_pkg::MODE_PLAIN |=> DMEM_ADDR == $past(rf.pd)
         && !rf.we ##1 !(rf.we && rf.wpair) && $stable(flag_ff))
      else $error("plain access moved the pointer");
endmodule

// ### core/bfl_pkg.sv
package bfl_pkg;
   // register map, byte addresses on the apb bus
   localparam logic [7:0]  ADDR_CMD   = 8'h00;
   localparam logic [7:0]  ADDR_ARG   = 8'h04;
   localparam logic [7:0]  ADDR_STAT  = 8'h08;
   localparam logic [7:0]  ADDR_RF    = 8'h80;

   // command word layout
   localparam int          CMD_W      = 22;
   localparam int          OPC_LSB    = 0;
   localparam int          DST_LSB    = 5;
   localparam int          SRC_LSB    = 10;
   localparam int          SEL_LSB    = 15;
   localparam int          PTR_LSB    = 18;
   localparam int          MODE_LSB   = 20;
   localparam int          DISP_W     = 6;

   // operation codes
   localparam logic [4:0]  OP_B2T     = 5'h00;
   localparam logic [4:0]  OP_T2B     = 5'h01;
   localparam logic [4:0]  OP_FSET    = 5'h02;
   localparam logic [4:0]  OP_FCLR    = 5'h03;
   localparam logic [4:0]  OP_MOV     = 5'h04;
   localparam logic [4:0]  OP_PCPY    = 5'h05;
   localparam logic [4:0]  OP_IMM     = 5'h06;
   localparam logic [4:0]  OP_LD      = 5'h07;
   localparam logic [4:0]  OP_DSP     = 5'h08;
   localparam logic [4:0]  OP_ABS     = 5'h09;
   localparam logic [4:0]  OP_ST      = 5'h0a;

   // pointer pairs and their modes
   localparam logic [1:0]  PTR_X      = 2'h0;
   localparam logic [1:0]  PTR_INVAL  = 2'h3;
   localparam logic [4:0]  PTR_BASE   = 5'h1a;
   localparam logic [1:0]  MODE_PLAIN = 2'h0;
   localparam logic [1:0]  MODE_INC   = 2'h1;
   localparam logic [1:0]  MODE_DEC   = 2'h2;
   localparam logic [1:0]  MODE_INVAL = 2'h3;

   // status flags register
   localparam int          FLG_T      = 6;
   localparam int          FLG_I      = 7;
   localparam logic [7:0]  T_MASK     = 8'h40;
   localparam logic [7:0]  FLAG_RST   = 8'h00;
   localparam int          STAT_BUSY  = 8;
   localparam int          STAT_BAD   = 9;

   typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_EXEC, ST_ACCESS, ST_WB} bfl_state_e;
endpackage

// ### core/bfl_regfile.sv
`timescale 1ns/1ps
module bfl_regfile #(
   parameter int DEPTH = 32
) (
   bfl_rf_if.mem rf
);
   // pointer pairs sit at the top, so the full set is needed
   if (DEPTH != 32) begin : g_chk
      $error("bfl_regfile: DEPTH must be 32");
   end

   logic [7:0] mem_ff [DEPTH];

   // registered reads, pair port gives high byte over low byte
   always_ff @(posedge rf.clk) begin
      rf.pd <= {mem_ff[{rf.pa[4:1], 1'b1}], mem_ff[{rf.pa[4:1], 1'b0}]};
      rf.sd <= mem_ff[rf.sa];
   end

   // one write per cycle, a single byte or an even-aligned pair
   always_ff @(posedge rf.clk) begin
      if (rf.we && rf.wpair) begin
         mem_ff[{rf.wa[4:1], 1'b0}] <= rf.wd[7:0];
         mem_ff[{rf.wa[4:1], 1'b1}] <= rf.wd[15:8];
      end else if (rf.we) begin
         mem_ff[rf.wa] <= rf.wd[7:0];
      end
   end
endmodule

// ### core/bfl_rf_if.sv
`timescale 1ns/1ps
interface bfl_rf_if (
   input wire logic clk
);
   logic [4:0]  pa;
   logic [15:0] pd;
   logic [4:0]  sa;
   logic [7:0]  sd;
   logic        we;
   logic        wpair;
   logic [4:0]  wa;
   logic [15:0] wd;

   modport mem (input clk, input pa, input sa, input we, input wpair, input wa, input wd,
                output pd, output sd);
   modport core (output pa, output sa, output we, output wpair, output wa, output wd,
                 input pd, input sd);
endinterface

// ### verification/bfl_dmem_model.sv
`timescale 1ns/1ps
// synchronous data memory facing the executor
module bfl_dmem_model (
   input  wire logic        clk,
   input  wire logic [15:0] addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        we,
   input  wire logic        re,
   output logic [7:0]       rdata
);
   logic [7:0] mem [logic [15:0]];

   initial rdata = 8'h00;

   // byte valid only in the cycle after re; it toggles otherwise so stale data is caught
   always @(posedge clk) begin
      if (we)
         mem[addr] = wdata;
      if (re)
         rdata <= mem.exists(addr) ? mem[addr] : (addr[7:0] ^ addr[15:8] ^ 8'h3c);
      else
         rdata <= ~rdata;
   end
endmodule

// ### verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
   logic        ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, dmem_we, dmem_re, interrupts_on;
   logic [7:0]  paddr, dmem_wdata, dmem_rdata, status_flags, fl;
   logic [31:0] pwdata, prdata;
   logic [15:0] dmem_addr;
   logic [32:0] rq[$], re_v;
   logic [24:0] mq[$], me_v;
   logic [7:0]  rf[32];
   logic [7:0]  tb_mem[logic [15:0]];
   logic [4:0]  r, d;
   logic [2:0]  b;
   int          fail_count, checks_done;

   always #25 ref_clk = ~ref_clk;

   bfl_exec DUT (.REF_CLK(ref_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
      .DMEM_ADDR(dmem_addr), .DMEM_WDATA(dmem_wdata), .DMEM_WE(dmem_we), .DMEM_RE(dmem_re),
      .DMEM_RDATA(dmem_rdata), .STATUS_FLAGS(status_flags), .INTERRUPTS_ON(interrupts_on));
   bfl_dmem_model u_mem (.clk(ref_clk), .addr(dmem_addr), .wdata(dmem_wdata), .we(dmem_we), .re(dmem_re),
      .rdata(dmem_rdata));

   task finish_test;
      $display("checks_done %0d fail_count %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // result watcher: each read answer and each memory strobe takes the oldest note
   always @(posedge ref_clk) begin
      if (psel && penable && pready && !pwrite) begin
         re_v = rq.size() ? rq.pop_front() : '1;
         `CHK({pslverr, prdata}, re_v)
      end
      if (dmem_re || dmem_we) begin
         me_v = mq.size() ? mq.pop_front() : '1;
         `CHK({dmem_we, dmem_addr, dmem_we ? dmem_wdata : 8'h00}, me_v)
      end
   end

   // apb master: request held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 100);
      if (n >= 100) begin
         fail_count++;
         finish_test();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [32:0] e);
      rq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask

   task wr_reg(input logic [4:0] n, input logic [7:0] v);
      apb(1'b1, bfl_pkg::ADDR_RF + {1'b0, n, 2'b00}, {24'h0, v});
      rf[n] = v;
   endtask

   task chk_reg(input logic [4:0] n);
      rd(bfl_pkg::ADDR_RF + {1'b0, n, 2'b00}, {25'h0, rf[n]});
   endtask

   // memory ops must strobe three edges after the command lands; others settle after two
   task cmd(input logic [4:0] op, dd, s, input logic [2:0] bb, input logic [1:0] p, m,
            input logic [15:0] k, input logic mo);
      int n;
      apb(1'b1, bfl_pkg::ADDR_ARG, {16'h0, k});
      apb(1'b1, bfl_pkg::ADDR_CMD, {10'h0, m, p, bb, s, dd, op});
      n = 0;
      if (mo) begin
         do begin @(posedge ref_clk); n++; end while (!(dmem_re || dmem_we) && n < 8);
         `CHK(n, 3)
         if (n >= 8)
            finish_test();
      end else begin
         repeat (2) @(posedge ref_clk);
         #1;
      end
   endtask

   function automatic logic [7:0] mval(input logic [15:0] a);
      return tb_mem.exists(a) ? tb_mem[a] : (a[7:0] ^ a[15:8] ^ 8'h3c);
   endfunction

   // one pointer or absolute access, with the pointer pair checked afterwards
   task mem_op(input logic [4:0] op, input logic [1:0] p, m, input logic [4:0] rr, input logic [15:0] pv, k);
      logic [15:0] a, np;
      logic [4:0]  lo;
      lo = bfl_pkg::PTR_BASE + {2'b00, p, 1'b0};
      wr_reg(lo, pv[7:0]);
      wr_reg(lo + 5'd1, pv[15:8]);
      a = (op == bfl_pkg::OP_ABS) ? k : (op == bfl_pkg::OP_DSP) ? pv + k :
          (m == bfl_pkg::MODE_DEC) ? pv - 16'h1 : pv;
      np = (m == bfl_pkg::MODE_INC) ? pv + 16'h1 : (m == bfl_pkg::MODE_DEC) ? pv - 16'h1 : pv;
      mq.push_back({op == bfl_pkg::OP_ST, a, (op == bfl_pkg::OP_ST) ? rf[rr] : 8'h00});
      if (op == bfl_pkg::OP_ST)
         tb_mem[a] = rf[rr];
      else
         rf[rr] = mval(a);
      cmd(op, rr, rr, 3'h0, p, m, k, 1'b1);
      rf[lo] = np[7:0];
      rf[lo + 5'd1] = np[15:8];
      chk_reg(rr);
      chk_reg(lo);
      chk_reg(lo + 5'd1);
      rd(bfl_pkg::ADDR_STAT, {25'h0, fl});
   endtask

   // main sequence
   initial begin
      ref_clk = 1'b0;
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fail_count = 0;
      checks_done = 0;
      void'($urandom(6220));
      repeat (6) @(posedge ref_clk);
      `CHK({status_flags, interrupts_on, dmem_re, dmem_we, pready}, 12'h0)
      reset_n <= 1'b1;
      for (int n = 0; n < 32; n++)
         wr_reg(5'(n), 8'($urandom));
      fl = 8'($urandom);
      apb(1'b1, bfl_pkg::ADDR_STAT, {24'h0, fl});
      for (int i = 0; i < 16; i++) begin
         fl[i % 8] = (i < 8);
         cmd((i < 8) ? bfl_pkg::OP_FSET : bfl_pkg::OP_FCLR, 5'h0, 5'h0, 3'(i), 2'h0, 2'h0, 16'h0, 1'b0);
         `CHK(status_flags, fl)
         `CHK(interrupts_on, fl[7])
      end
      for (int i = 0; i < 6; i++) begin
         r = 5'($urandom_range(0, 25));
         b = 3'($urandom);
         fl[bfl_pkg::FLG_T] = rf[r][b];
         cmd(bfl_pkg::OP_B2T, 5'h0, r, b, 2'h0, 2'h0, 16'h0, 1'b0);
         `CHK(status_flags, fl)
         d = 5'($urandom_range(0, 25));
         b = 3'($urandom);
         rf[d][b] = fl[bfl_pkg::FLG_T];
         cmd(bfl_pkg::OP_T2B, d, 5'h0, b, 2'h0, 2'h0, 16'h0, 1'b0);
         `CHK(status_flags, fl)
         chk_reg(d);
      end
      d = 5'($urandom_range(0, 25));
      r = 5'($urandom_range(0, 25));
      rf[d] = rf[r];
      cmd(bfl_pkg::OP_MOV, d, r, 3'h0, 2'h0, 2'h0, 16'h0, 1'b0);
      chk_reg(d);
      d = 5'(2 * $urandom_range(0, 12));
      r = 5'(2 * $urandom_range(0, 12));
      rf[d] = rf[r];
      rf[d + 5'd1] = rf[r + 5'd1];
      cmd(bfl_pkg::OP_PCPY, d, r, 3'h0, 2'h0, 2'h0, 16'h0, 1'b0);
      chk_reg(d);
      chk_reg(d + 5'd1);
      rf[d] = 8'($urandom);
      cmd(bfl_pkg::OP_IMM, d, 5'h0, 3'h0, 2'h0, 2'h0, {8'h0, rf[d]}, 1'b0);
      chk_reg(d);
      rd(bfl_pkg::ADDR_STAT, {25'h0, fl});
      for (int p = 0; p < 3; p++)
         for (int m = 0; m < 3; m++) begin
            mem_op(bfl_pkg::OP_ST, 2'(p), 2'(m), 5'($urandom_range(0, 25)), 16'($urandom), 16'h0);
            mem_op(bfl_pkg::OP_LD, 2'(p), 2'(m), 5'($urandom_range(0, 25)), 16'($urandom), 16'h0);
         end
      mem_op(bfl_pkg::OP_DSP, 2'h1, 2'h0, 5'h3, 16'($urandom), 16'($urandom_range(0, 62)));
      mem_op(bfl_pkg::OP_DSP, 2'h2, 2'h0, 5'h4, 16'($urandom), 16'h3f);
      mem_op(bfl_pkg::OP_ABS, 2'h0, 2'h0, 5'h5, 16'($urandom), 16'($urandom));
      // refused: unknown code, missing pointer, missing mode, displaced through X; no strobe expected
      for (int i = 0; i < 4; i++) begin
         cmd((i == 0) ? 5'h1f : (i == 1) ? bfl_pkg::OP_LD : (i == 2) ? bfl_pkg::OP_ST : bfl_pkg::OP_DSP,
             5'h0, 5'h0, 3'h0, (i == 1) ? bfl_pkg::PTR_INVAL : bfl_pkg::PTR_X,
             (i == 2) ? bfl_pkg::MODE_INVAL : bfl_pkg::MODE_PLAIN, 16'h0, 1'b0);
         rd(bfl_pkg::ADDR_STAT, {23'h0, 2'b10, fl});
         apb(1'b1, bfl_pkg::ADDR_STAT, {22'h0, 2'b10, fl});
         rd(bfl_pkg::ADDR_STAT, {25'h0, fl});
      end
      rd(8'h0c, {1'b1, 32'h0});
      rd(8'h81, {1'b1, 32'h0});
      @(posedge ref_clk);
      `CHK(rq.size() + mq.size(), 0)
      finish_test();
   end
endmodule
